// file: src/flash_reset_ctl.sv
// Reset, pause, select and write-protect control of a serial flash
`timescale 1ns/100ps
`default_nettype none
`include "flash_reset_params.svh"

module flash_reset_ctl #(
	parameter int SW_RESET_CYCLES      = `SW_RESET_CYCLES,
	parameter int POWERUP_WRITE_CYCLES = `POWERUP_WRITE_CYCLES
) (
	input  wire logic                           clk_i,                        // 125 MHz clock
	input  wire logic                           rst_i,                        // Async reset, high
	input  wire logic                           por_i,                        // Power-on clear, high
	input  wire logic                           cs_n_i,                       // Chip select pin, low
	input  wire logic                           sclk_i,                       // Serial clock pin
	input  wire logic                           si_i,                         // Serial data in pin
	input  wire logic                           shared_pin_i,                 // Pause/reset/IO3 pin
	input  wire logic                           reset_n_i,                    // Dedicated reset pin
	input  wire logic                           quad_io_enable_i,             // Quad enable bit
	input  wire logic                           pin_function_select_i,        // Shared pin role
	input  wire logic                           protection_scheme_select_i,   // Protection scheme
	input  wire logic                           complement_protect_i,         // Complement bit
	input  wire flash_reset_pkg::block_protect_t block_protect_bits_i,        // Block protect bits
	input  wire logic                           bp_area_hit_i,                // Target in BP area
	input  wire logic                           persistent_sector_lock_i,     // Target persistent lock
	input  wire logic                           dynamic_sector_lock_i,        // Target dynamic lock
	input  wire logic                           write_in_progress_i,          // Internal write busy
	input  wire logic                           deep_power_down_i,            // Deep power-down mode
	input  wire logic                           cmd_valid_i,                  // Decoded opcode strobe
	input  wire flash_reset_pkg::opcode_t       cmd_code_i,                   // Decoded opcode
	input  wire logic                           so_drive_req_i,               // Core wants SO driven
	input  wire logic                           io0_drive_req_i,              // Core wants IO0 driven
	output logic                                cmd_accept_o,                 // Opcode accepted
	output logic                                array_write_ok_o,             // Program/erase proceeds
	output logic                                selected_o,                   // Device selected
	output logic                                standby_o,                    // Standby power mode
	output logic                                pause_o,                      // Pause active
	output logic                                sclk_rise_o,                  // Qualified clock rise
	output logic                                si_o,                         // Synchronised data in
	output logic                                so_oe_n_o,                    // SO enable, low drives
	output logic                                io0_oe_n_o,                   // IO0 enable, low drives
	output logic                                dev_reset_o,                  // Internal reset level
	output logic                                abort_o,                      // Abandon pending work
	output logic                                write_enable_latch_o,         // Write enable latch
	output logic                                writes_unlocked_o             // Power-up delay over
);
	import flash_reset_pkg::*;

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	logic [5:0] pins_s;
	logic       por_s, cs_n_s, sclk_s, si_s, shared_s, reset_n_s;

	pin_sync #(
		.W       (6),
		.RST_VAL (6'h33)
	) u_sync (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.d_i   ({por_i, cs_n_i, sclk_i, si_i, shared_pin_i, reset_n_i}),
		.q_o   (pins_s)
	);

	assign {por_s, cs_n_s, sclk_s, si_s, shared_s, reset_n_s} = pins_s;

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	ctl_state_t           state_reg, state_next;
	logic                 cs_n_d_reg, sclk_d_reg, shared_d_reg;
	logic                 sel_reg, sel_next;
	logic                 pause_reg, pause_next;
	logic                 sclk_seen_reg, sclk_seen_next;
	logic                 armed_reg, armed_next;
	logic [1:0]           step_reg, step_next;
	logic                 wel_reg, wel_next;
	logic                 unlocked_reg, unlocked_next;
	logic                 abort_reg, abort_next;
	logic                 si_reg;
	logic [`TIMER_W-1:0]  timer_reg, timer_next;
	logic [`TIMER_W-1:0]  pup_reg, pup_next;
	logic [`TIMER_W-1:0]  rpulse_reg, rpulse_next;

	// ----------------------------------------------------------------
	// Edge and role decode
	// ----------------------------------------------------------------
	wire cs_fall     = cs_n_d_reg & ~cs_n_s;
	wire cs_rise     = ~cs_n_d_reg & cs_n_s;
	wire sclk_edge   = sclk_d_reg ^ sclk_s;
	wire sclk_rise   = ~sclk_d_reg & sclk_s;
	wire shared_fall = shared_d_reg & ~shared_s;
	wire shared_rise = ~shared_d_reg & shared_s;

	wire pause_role  = ~quad_io_enable_i & ~pin_function_select_i;
	wire reset_role  = ~quad_io_enable_i & pin_function_select_i;
	wire pin_low     = ~reset_n_s | (reset_role & ~shared_s);

	wire pause_start = pause_role & ~pause_reg & sel_reg & shared_fall & ~sclk_s;
	wire pause_end   = pause_reg & shared_rise & ~sclk_s;
	wire pause_drop  = pause_reg & cs_rise;

	wire pin_done    = rpulse_reg >= `TIMER_W'(`PIN_PULSE_MIN_CYCLES);
	wire sw_done     = timer_reg >= `TIMER_W'(SW_RESET_CYCLES - 1);
	wire pup_done    = pup_reg >= `TIMER_W'(POWERUP_WRITE_CYCLES);

	// ----------------------------------------------------------------
	// Instruction classification
	// ----------------------------------------------------------------
	wire op_en_rst   = cmd_code_i == `OP_ENABLE_RESET;
	wire op_rst      = cmd_code_i == `OP_RESET;
	wire op_wren     = cmd_code_i == `OP_WRITE_ENABLE;
	wire op_wrdi     = cmd_code_i == `OP_WRITE_DISABLE;
	wire op_wrsr     = (cmd_code_i == `OP_WRITE_STATUS) | (cmd_code_i == `OP_WRITE_EXT_ADDR);
	wire op_lock     = (cmd_code_i == `OP_LOCK_WRITE_A) | (cmd_code_i == `OP_LOCK_WRITE_B);
	wire op_chip     = cmd_code_i == `OP_CHIP_ERASE;
	wire op_prog     = (cmd_code_i == `OP_PAGE_PROGRAM) | (cmd_code_i == `OP_SECTOR_ERASE)
	                 | (cmd_code_i == `OP_BLOCK_ERASE) | op_chip;
	wire op_write    = op_wren | op_wrsr | op_prog;

	// Gate: reset states, power-on clear, pause and deep power-down
	wire ready       = (state_reg == ST_READY) & ~por_s & ~pin_low & sel_reg & ~pause_reg;
	wire dpd_block   = deep_power_down_i & (cmd_code_i != `OP_RELEASE_DPD);
	wire pup_block   = op_write & ~unlocked_reg;
	wire accept      = cmd_valid_i & ready & ~dpd_block & ~pup_block;

	// Array permission by selected protection scheme
	wire [`BP_LOW_FIELD_MSB:0] bp_low = block_protect_bits_i[`BP_LOW_FIELD_MSB:0];
	wire chip_free   = ((bp_low == `BP_LOW_ALL_ZERO) & ~complement_protect_i)
	                 | ((bp_low == `BP_LOW_ALL_ONES) & complement_protect_i);
	wire bp_free     = op_chip ? chip_free : ~bp_area_hit_i;
	wire lock_free   = ~(persistent_sector_lock_i | dynamic_sector_lock_i);
	wire target_free = protection_scheme_select_i ? lock_free : bp_free;

	// ----------------------------------------------------------------
	// Chip-select reset sequence detector
	// ----------------------------------------------------------------
	wire cs_bit_ok   = si_s == step_reg[0];
	wire cs_seq_hit  = cs_rise & cs_bit_ok & (step_reg == `CS_RESET_STEPS)
	                 & (state_reg != ST_HW_RESET);

	always_comb begin
		step_next = step_reg;
		if (sclk_edge) begin
			step_next = 2'h0;
		end else if (cs_rise) begin
			if (!cs_bit_ok) begin
				step_next = {1'b0, ~si_s};
			end else begin
				step_next = step_reg + 2'h1;
			end
		end
	end

	// ----------------------------------------------------------------
	// Control state machine
	// ----------------------------------------------------------------
	wire sw_reset_go = accept & op_rst & armed_reg;

	always_comb begin
		state_next = state_reg;
		timer_next = timer_reg;
		case (state_reg)
			ST_WAIT_CS: begin
				if (cs_fall) begin
					state_next = ST_READY;
				end
			end
			ST_READY: begin
				if (sw_reset_go || cs_seq_hit) begin
					state_next = ST_SW_RESET;
					timer_next = '0;
				end
			end
			ST_SW_RESET: begin
				timer_next = timer_reg + `TIMER_W'(1);
				if (sw_done) begin
					state_next = ST_READY;
				end
			end
			ST_HW_RESET: begin
				if (!pin_low) begin
					state_next = ST_READY;
				end
			end
			default: begin
				state_next = ST_WAIT_CS;
			end
		endcase
		if (pin_low && pin_done) begin
			state_next = ST_HW_RESET;
		end
		if (por_s) begin
			state_next = ST_WAIT_CS;
			timer_next = '0;
		end
	end

	// ----------------------------------------------------------------
	// Select, pause, clock tracking and latches
	// ----------------------------------------------------------------
	wire any_reset = por_s | (state_next == ST_SW_RESET) | (state_next == ST_HW_RESET);

	always_comb begin
		sel_next       = sel_reg;
		pause_next     = pause_reg;
		sclk_seen_next = sclk_seen_reg;
		armed_next     = armed_reg;
		wel_next       = wel_reg;
		abort_next     = pause_drop | (pin_low & pin_done & (state_reg != ST_HW_RESET));
		if (cs_n_s) begin
			sel_next = 1'b0;
		end else if (cs_fall && state_next == ST_READY) begin
			sel_next = 1'b1;
		end
		if (pause_start) begin
			pause_next = 1'b1;
		end else if (pause_end || pause_drop || !pause_role) begin
			pause_next = 1'b0;
		end
		if (cs_fall) begin
			sclk_seen_next = 1'b0;
		end else if (sclk_edge && sel_reg && !pause_reg) begin
			sclk_seen_next = 1'b1;
		end
		if (accept) begin
			armed_next = op_en_rst;
			if (op_wren) begin
				wel_next = 1'b1;
			end else if (op_wrdi || op_wrsr || op_prog || (op_lock && protection_scheme_select_i)) begin
				wel_next = 1'b0;
			end
		end
		if (any_reset || pause_drop) begin
			armed_next = 1'b0;
		end
		if (any_reset) begin
			wel_next = `WEL_RESET;
			sel_next = 1'b0;
			pause_next = 1'b0;
		end
	end

	// Power-up write delay and reset pulse width
	always_comb begin
		pup_next    = pup_reg;
		rpulse_next = '0;
		unlocked_next = unlocked_reg | pup_done;
		if (por_s) begin
			pup_next      = '0;
			unlocked_next = 1'b0;
		end else if (!pup_done) begin
			pup_next = pup_reg + `TIMER_W'(1);
		end
		if (pin_low) begin
			rpulse_next = pin_done ? rpulse_reg : rpulse_reg + `TIMER_W'(1);
		end
	end

	// ----------------------------------------------------------------
	// State registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			state_reg     <= ST_WAIT_CS;
			timer_reg     <= '0;
			pup_reg       <= '0;
			rpulse_reg    <= '0;
			step_reg      <= 2'h0;
			sel_reg       <= 1'b0;
			pause_reg     <= 1'b0;
			sclk_seen_reg <= 1'b0;
			armed_reg     <= 1'b0;
			wel_reg       <= `WEL_RESET;
			unlocked_reg  <= 1'b0;
			abort_reg     <= 1'b0;
		end else begin
			state_reg     <= state_next;
			timer_reg     <= timer_next;
			pup_reg       <= pup_next;
			rpulse_reg    <= rpulse_next;
			step_reg      <= step_next;
			sel_reg       <= sel_next;
			pause_reg     <= pause_next;
			sclk_seen_reg <= sclk_seen_next;
			armed_reg     <= armed_next;
			wel_reg       <= wel_next;
			unlocked_reg  <= unlocked_next;
			abort_reg     <= abort_next;
		end
	end

	// Edge history and held data input
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			cs_n_d_reg   <= 1'b1;
			sclk_d_reg   <= 1'b0;
			shared_d_reg <= 1'b1;
			si_reg       <= 1'b0;
		end else begin
			cs_n_d_reg   <= cs_n_s;
			sclk_d_reg   <= sclk_s;
			shared_d_reg <= shared_s;
			if (!pause_reg) begin
				si_reg <= si_s;
			end
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign cmd_accept_o         = accept;
	assign array_write_ok_o     = accept & op_prog & wel_reg & target_free;
	assign selected_o           = sel_reg;
	assign standby_o            = ~sel_reg & ~write_in_progress_i;
	assign pause_o              = pause_reg;
	assign sclk_rise_o          = sclk_rise & sel_reg & ~pause_reg;
	assign si_o                 = si_reg;
	assign so_oe_n_o            = ~(so_drive_req_i & sel_reg & ~pause_reg & sclk_seen_reg);
	assign io0_oe_n_o           = ~(io0_drive_req_i & sel_reg & ~pause_reg & sclk_seen_reg);
	assign dev_reset_o          = por_s | (state_reg == ST_SW_RESET) | (state_reg == ST_HW_RESET);
	assign abort_o              = abort_reg;
	assign write_enable_latch_o = wel_reg;
	assign writes_unlocked_o    = unlocked_reg;

endmodule

`default_nettype wire

// file: src/flash_reset_params.svh
// Constants for the flash reset, pause and write-protect control block
`ifndef FLASH_RESET_PARAMS_SVH
`define FLASH_RESET_PARAMS_SVH

// ----------------------------------------------------------------
// Clock and timing
// ----------------------------------------------------------------
`define CLK_PERIOD_NS           8
`define SW_RESET_TIME_US        300
`define SW_RESET_CYCLES         ((`SW_RESET_TIME_US * 1000) / `CLK_PERIOD_NS)
`define PIN_PULSE_MIN_NS        1000
`define PIN_PULSE_MIN_CYCLES    ((`PIN_PULSE_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define POWERUP_WRITE_DELAY_US  100
`define POWERUP_WRITE_CYCLES    ((`POWERUP_WRITE_DELAY_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define TIMER_W                 20

// ----------------------------------------------------------------
// Instruction codes
// ----------------------------------------------------------------
`define OP_ENABLE_RESET         8'h66
`define OP_RESET                8'h99
`define OP_WRITE_ENABLE         8'h06
`define OP_WRITE_DISABLE        8'h04
`define OP_WRITE_STATUS         8'h01
`define OP_WRITE_EXT_ADDR       8'hC5
`define OP_PAGE_PROGRAM         8'h02
`define OP_SECTOR_ERASE         8'h20
`define OP_BLOCK_ERASE          8'hD8
`define OP_CHIP_ERASE           8'hC7
`define OP_LOCK_WRITE_A         8'hE3
`define OP_LOCK_WRITE_B         8'hE1
`define OP_RELEASE_DPD          8'hAB

// ----------------------------------------------------------------
// Reset values and field layout
// ----------------------------------------------------------------
`define CS_RESET_PATTERN        4'h5
`define CS_RESET_STEPS          2'h3
`define BP_LOW_FIELD_MSB        2
`define BP_LOW_ALL_ONES         3'h7
`define BP_LOW_ALL_ZERO         3'h0
`define WEL_RESET               1'b0

`endif

// file: src/flash_reset_pkg.sv
// Types for the flash reset, pause and write-protect control block
package flash_reset_pkg;

	// Control states, Gray coded along wait -> ready -> software reset path
	typedef enum logic [1:0] {
		ST_WAIT_CS  = 2'h0,
		ST_READY    = 2'h1,
		ST_SW_RESET = 2'h3,
		ST_HW_RESET = 2'h2
	} ctl_state_t;

	typedef logic [7:0] opcode_t;
	typedef logic [4:0] block_protect_t;

endpackage

// file: src/pin_sync.sv
// Two-stage synchroniser for asynchronous pin inputs
`timescale 1ns/100ps
`default_nettype none

module pin_sync #(
	parameter int                 W       = 1,
	parameter logic [W-1:0]       RST_VAL = '0
) (
	input  wire logic             clk_i,    // Sampling clock
	input  wire logic             rst_i,    // Async reset, high
	input  wire logic [W-1:0]     d_i,      // Asynchronous inputs
	output logic      [W-1:0]     q_o       // Synchronised outputs
);

	logic [W-1:0] meta_reg;

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			meta_reg <= RST_VAL;
			q_o      <= RST_VAL;
		end else begin
			meta_reg <= d_i;
			q_o      <= meta_reg;
		end
	end

endmodule

`default_nettype wire

// file: testbench/flash_reset_monitor.sv
// Port checker for the flash reset, pause and protect control block
`timescale 1ns/100ps
`default_nettype none
module flash_reset_monitor (
	input wire logic                     clk_i,                      // Clock
	input wire logic                     rst_i,                      // Reset
	input wire logic                     por_i,                      // Power clear
	input wire logic                     reset_n_i,                  // Reset pin
	input wire logic                     protection_scheme_select_i, // Scheme
	input wire logic                     persistent_sector_lock_i,   // Lock
	input wire logic                     dynamic_sector_lock_i,      // Lock
	input wire logic                     deep_power_down_i,          // Power-down
	input wire flash_reset_pkg::opcode_t cmd_code_i,                 // Opcode
	input wire logic                     cmd_accept_o,               // Accept
	input wire logic                     array_write_ok_o,           // Write ok
	input wire logic                     pause_o,                    // Pause
	input wire logic                     so_oe_n_o,                  // Out enable
	input wire logic                     dev_reset_o,                // Reset level
	input wire logic                     write_enable_latch_o,       // Latch
	input wire logic                     writes_unlocked_o           // Unlocked
);
	import flash_reset_pkg::*;
	// ------------------------------------------------
	// Assertions
	// ------------------------------------------------
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	a_por_blocks_cmd: assert property (por_i [*3] |-> !cmd_accept_o)
		else $error("command taken during power clear");
	a_pin_blocks_cmd: assert property (!reset_n_i [*4] |-> !cmd_accept_o)
		else $error("command taken with reset pin low");
	a_dpd_only_release: assert property (cmd_accept_o && deep_power_down_i |-> cmd_code_i == 8'hAB)
		else $error("command taken in power-down");
	a_early_write: assert property (cmd_accept_o && cmd_code_i inside {8'h06, 8'h02, 8'h20, 8'hD8, 8'hC7, 8'h01}
		|-> writes_unlocked_o)
		else $error("write command before delay");
	a_wel_cmd_clear: assert property (cmd_accept_o && cmd_code_i inside {8'h04, 8'h01, 8'hC5, 8'h02, 8'h20, 8'hD8,
		8'hC7} |=> !write_enable_latch_o)
		else $error("latch kept after clearing command");
	a_wel_reset_clear: assert property (dev_reset_o |=> !write_enable_latch_o)
		else $error("latch kept through reset");
	a_lock_blocks_write: assert property (array_write_ok_o && protection_scheme_select_i
		|-> !persistent_sector_lock_i && !dynamic_sector_lock_i)
		else $error("write to locked target");
	a_pause_hiz: assert property (pause_o |-> so_oe_n_o)
		else $error("output driven in pause");
endmodule
bind flash_reset_ctl flash_reset_monitor u_mon (.clk_i, .rst_i, .por_i, .reset_n_i, .protection_scheme_select_i,
	.persistent_sector_lock_i, .dynamic_sector_lock_i, .deep_power_down_i, .cmd_code_i, .cmd_accept_o,
	.array_write_ok_o, .pause_o, .so_oe_n_o, .dev_reset_o, .write_enable_latch_o, .writes_unlocked_o);
`default_nettype wire

// file: testbench/flash_host_model.sv
// Host model driving select, serial clock and data pins
`timescale 1ns/100ps
`default_nettype none
module flash_host_model (
	output logic cs_n_o, // Chip select
	output logic sclk_o, // Serial clock
	output logic si_o    // Serial data
);
	initial begin
		cs_n_o = 1'b0;
		sclk_o = 1'b0;
		si_o = 1'b0;
	end
	task automatic cs(input logic v);
		cs_n_o = v;
	endtask
	task automatic data(input logic b);
		si_o = b;
	endtask
	task automatic tick;
		sclk_o = 1'b1;
		#40 sclk_o = 1'b0;
		#40;
	endtask
	// Data set with the select fall, held past the rise, then flipped
	task automatic pulse(input logic b);
		si_o = b;
		cs_n_o = 1'b0;
		#80 cs_n_o = 1'b1;
		#40 si_o = ~b;
		#40;
	endtask
endmodule
`default_nettype wire

// file: testbench/test_flash_reset_ctl.sv
// Self-checking bench for the flash reset control block
`timescale 1ns/100ps
`default_nettype none
module test_flash_reset_ctl;
	import flash_reset_pkg::*;
	localparam int SW_CYC = 50;
	localparam int PU_CYC = 200;
	// Opcode, power-down, persistent and dynamic lock, accept, write ok, latch
	localparam logic [13:0] ROWS [23] = '{{8'h06, 6'h05}, {8'h04, 6'h04}, {8'h06, 6'h05}, {8'h01, 6'h04},
		{8'h06, 6'h05}, {8'hC5, 6'h04}, {8'h06, 6'h05}, {8'h02, 6'h06}, {8'h06, 6'h05}, {8'h20, 6'h06},
		{8'h06, 6'h05}, {8'hD8, 6'h06}, {8'h06, 6'h05}, {8'hC7, 6'h06}, {8'h06, 6'h05}, {8'h02, 6'h14},
		{8'h06, 6'h05}, {8'h20, 6'h0C}, {8'h06, 6'h05}, {8'hE3, 6'h05}, {8'hE1, 6'h1C}, {8'h06, 6'h20},
		{8'hAB, 6'h24}};
	localparam logic [4:0] PAT [3] = '{5'h0A, 5'h0A, 5'h14};
	logic clk_i = 1'b0, rst_i = 1'b1, por_i = 1'b1, shared_pin_i = 1'b1, reset_n_i = 1'b1;
	logic quad_io_enable_i = 1'b0, pin_function_select_i = 1'b0, protection_scheme_select_i = 1'b0;
	logic complement_protect_i = 1'b0, bp_area_hit_i = 1'b0, persistent_sector_lock_i = 1'b0;
	logic dynamic_sector_lock_i = 1'b0, write_in_progress_i = 1'b0, deep_power_down_i = 1'b0;
	logic cmd_valid_i = 1'b0, so_drive_req_i = 1'b0, io0_drive_req_i = 1'b0;
	block_protect_t block_protect_bits_i = 5'h00;
	opcode_t cmd_code_i = 8'h00;
	wire logic cs_n_i, sclk_i, si_i;
	logic cmd_accept_o, array_write_ok_o, selected_o, standby_o, pause_o, so_oe_n_o, io0_oe_n_o;
	logic dev_reset_o, abort_o, write_enable_latch_o, writes_unlocked_o, sclk_rise_o, si_o;
	int n_rise = 0;
	wire logic [3:0] mon = {abort_o, dev_reset_o, pause_o, selected_o};
	int mismatches = 0, n_tests = 0, n;
	always #4 clk_i = ~clk_i;
	always @(posedge clk_i)
		if (sclk_rise_o === 1'b1)
			n_rise++;
	flash_host_model u_host (.cs_n_o(cs_n_i), .sclk_o(sclk_i), .si_o(si_i));
	flash_reset_ctl #(.SW_RESET_CYCLES(SW_CYC), .POWERUP_WRITE_CYCLES(PU_CYC)) u_dut (
		.clk_i, .rst_i, .por_i, .cs_n_i, .sclk_i, .si_i, .shared_pin_i, .reset_n_i,
		.quad_io_enable_i, .pin_function_select_i, .protection_scheme_select_i, .complement_protect_i,
		.block_protect_bits_i, .bp_area_hit_i, .persistent_sector_lock_i, .dynamic_sector_lock_i,
		.write_in_progress_i, .deep_power_down_i, .cmd_valid_i, .cmd_code_i, .so_drive_req_i,
		.io0_drive_req_i, .cmd_accept_o, .array_write_ok_o, .selected_o, .standby_o, .pause_o,
		.sclk_rise_o, .si_o, .so_oe_n_o, .io0_oe_n_o, .dev_reset_o, .abort_o,
		.write_enable_latch_o, .writes_unlocked_o);
	task automatic give_verdict;
		$display("comparisons %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic chk(input logic got, input logic exp);
		n_tests++;
		if (got !== exp) begin
			mismatches++;
			$display("ERROR t=%0t got %b expected %b", $time, got, exp);
		end
	endtask
	task automatic wt(input int k, input logic v);
		int i;
		for (i = 0; i < 400 && mon[k] !== v; i++)
			@(negedge clk_i);
		if (i == 400) begin
			mismatches++;
			$display("ERROR t=%0t wait expired on output %0d", $time, k);
			give_verdict();
		end
	endtask
	task automatic cmd(input opcode_t c, input logic acc, input logic ok);
		@(negedge clk_i);
		cmd_code_i = c;
		cmd_valid_i = 1'b1;
		#2 chk(cmd_accept_o, acc);
		chk(array_write_ok_o, ok);
		@(negedge clk_i);
		cmd_valid_i = 1'b0;
	endtask
	task automatic reselect;
		u_host.cs(1'b1);
		repeat (6) @(negedge clk_i);
		u_host.cs(1'b0);
		wt(0, 1'b1);
	endtask
	// ------------------------------------------------
	// Main sequence
	// ------------------------------------------------
	initial begin
		repeat (2) @(negedge clk_i);
		rst_i = 1'b0;
		repeat (4) @(negedge clk_i);
		chk(dev_reset_o, 1'b1);
		por_i = 1'b0;
		repeat (20) @(negedge clk_i);
		chk(selected_o, 1'b0);
		reselect();
		cmd(8'h06, 1'b0, 1'b0);
		repeat (PU_CYC) @(negedge clk_i);
		foreach (ROWS[i]) begin
			{deep_power_down_i, persistent_sector_lock_i, dynamic_sector_lock_i} = ROWS[i][5:3];
			protection_scheme_select_i = |ROWS[i][4:3];
			cmd(ROWS[i][13:6], ROWS[i][2], ROWS[i][1]);
			chk(write_enable_latch_o, ROWS[i][0]);
		end
		{deep_power_down_i, persistent_sector_lock_i, dynamic_sector_lock_i} = 3'h0;
		{so_drive_req_i, io0_drive_req_i} = 2'h3;
		reselect();
		chk(io0_oe_n_o, 1'b1);
		u_host.tick();
		@(negedge clk_i);
		chk(so_oe_n_o, 1'b0);
		chk(n_rise == 1, 1'b1);
		{quad_io_enable_i, shared_pin_i} = 2'h2;
		repeat (8) @(negedge clk_i);
		chk(pause_o, 1'b0);
		{quad_io_enable_i, shared_pin_i} = 2'h1;
		repeat (8) @(negedge clk_i);
		shared_pin_i = 1'b0;
		wt(1, 1'b1);
		chk(so_oe_n_o, 1'b1);
		u_host.data(1'b1);
		repeat (4) @(negedge clk_i);
		chk(si_o, 1'b0);
		u_host.data(1'b0);
		u_host.cs(1'b1);
		wt(3, 1'b1);
		repeat (2) @(negedge clk_i);
		chk(pause_o, 1'b0);
		shared_pin_i = 1'b1;
		wt(0, 1'b0);
		write_in_progress_i = 1'b1;
		#1 chk(standby_o, 1'b0);
		@(negedge clk_i);
		write_in_progress_i = 1'b0;
		#1 chk(standby_o, 1'b1);
		reselect();
		cmd(8'h06, 1'b1, 1'b0);
		cmd(8'h66, 1'b1, 1'b0);
		cmd(8'h99, 1'b1, 1'b0);
		cmd(8'h06, 1'b0, 1'b0);
		for (n = 2; n < 400 && dev_reset_o === 1'b1; n++)
			@(negedge clk_i);
		chk(n >= SW_CYC - 1 && n <= SW_CYC + 1, 1'b1);
		chk(write_enable_latch_o, 1'b0);
		for (int k = 0; k < 2; k++) begin
			reselect();
			cmd(8'h06, 1'b1, 1'b0);
			{quad_io_enable_i, pin_function_select_i} = k ? 2'h1 : 2'h3;
			{shared_pin_i, reset_n_i} = k ? 2'h1 : 2'h2;
			repeat (4) @(negedge clk_i);
			cmd(8'h66, 1'b0, 1'b0);
			wt(3, 1'b1);
			chk(dev_reset_o, 1'b1);
			@(negedge clk_i);
			chk(write_enable_latch_o, 1'b0);
			{shared_pin_i, reset_n_i} = 2'h3;
			wt(2, 1'b0);
		end
		{quad_io_enable_i, pin_function_select_i} = 2'h0;
		for (int k = 0; k < 3; k++) begin
			u_host.cs(1'b1);
			repeat (6) @(negedge clk_i);
			for (int i = 0; i < 4 + k / 2; i++) begin
				if (k == 1 && i == 2)
					u_host.tick();
				u_host.pulse(PAT[k][i]);
			end
			@(negedge clk_i);
			chk(dev_reset_o, k != 1);
			wt(2, 1'b0);
		end
		give_verdict();
	end
endmodule
`default_nettype wire
